// file: slc_link_control.sv
// Purpose: Link control register of the serial link bridge.
// Assumes: Config write and read strobes are one-cycle pulses on clk.
// Notes:   Two fields take their reset value from the general control
//          register, which lives outside this block.
`timescale 1ns/1ps

// Function
// - Bits 15:12 read zero, writes ignored.
// - Bits 11, 10, 9 held at zero.
// - Clock power off keeps clock request low.
// - Clock power enable loads from general control.
// - Extended sync lengthens FTS, adds TS2.
// - Common clock bit selects reported exit latency.
// - Retrain and disable read zero, no action.
// - Boundary bit stored; own boundary stays 128.
// - Bit 2 reads zero, writes ignored.
// - Power state field decodes L0s/L1 permits.
// - Power state field loads from general control.
// - L0s latency 011b common, 100b asynchronous.
module slc_link_control
  import slc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration access
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output logic [15:0]      cfg_rdata,
  output logic             cfg_hit,
  // General control defaults
  input  wire logic [31:0] gen_control,
  // Link side
  input  wire logic        link_idle,
  output logic             clk_req_n_out,
  output logic             ext_sync,
  output logic             l0s_permit,
  output logic             l1_permit,
  output logic [2:0]       l0s_exit_latency,
  output logic             common_clock,
  output logic             own_boundary_128
);

  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic       clk_pwr_r,   clk_pwr_nxt;
  logic       ext_sync_r,  ext_sync_nxt;
  logic       common_r,    common_nxt;
  logic       bound_r,     bound_nxt;
  logic [1:0] psc_r,       psc_nxt;
  logic       load_def_r,  load_def_nxt;
  logic [15:0] rdata_r,    rdata_nxt;
  logic       clk_req_r,   clk_req_nxt;
  logic       sel;
  logic [15:0] wmask;
  logic [15:0] cur;

  assign sel   = (cfg_addr == SLC_LINK_CONTROL_OFS);
  assign wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & SLC_WRITE_MASK;

  // Current image; fixed-zero bits never get a flip-flop.
  always_comb begin
    cur = 16'h0000;
    cur[SLC_POS_CLK_PWR]     = clk_pwr_r;
    cur[SLC_POS_EXT_SYNC]    = ext_sync_r;
    cur[SLC_POS_COMMON_CLK]  = common_r;
    cur[SLC_POS_COMPL_BOUND] = bound_r;
    cur[SLC_POS_PSC_HI:SLC_POS_PSC_LO] = psc_r;
  end

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    clk_pwr_nxt  = clk_pwr_r;
    ext_sync_nxt = ext_sync_r;
    common_nxt   = common_r;
    bound_nxt    = bound_r;
    psc_nxt      = psc_r;
    load_def_nxt = 1'b0;
    rdata_nxt    = rdata_r;
    if (load_def_r) begin
      // Defaults are taken one cycle after reset release so no port is
      // sampled under reset.
      clk_pwr_nxt = gen_control[SLC_POS_GEN_CLK_PWR];
      psc_nxt = gen_control[SLC_POS_GEN_PSC_HI:SLC_POS_GEN_PSC_LO];
    end
    if (sel && cfg_wr) begin
      if (wmask[SLC_POS_CLK_PWR]) begin
        clk_pwr_nxt = cfg_wdata[SLC_POS_CLK_PWR];
      end
      if (wmask[SLC_POS_EXT_SYNC]) begin
        ext_sync_nxt = cfg_wdata[SLC_POS_EXT_SYNC];
      end
      if (wmask[SLC_POS_COMMON_CLK]) begin
        common_nxt = cfg_wdata[SLC_POS_COMMON_CLK];
      end
      if (wmask[SLC_POS_COMPL_BOUND]) begin
        bound_nxt = cfg_wdata[SLC_POS_COMPL_BOUND];
      end
      if (wmask[SLC_POS_PSC_LO]) begin
        psc_nxt = cfg_wdata[SLC_POS_PSC_HI:SLC_POS_PSC_LO];
      end
    end
    if (sel && cfg_rd) begin
      rdata_nxt = cur;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_pwr_r  <= SLC_CLK_PWR_RST;
      ext_sync_r <= SLC_EXT_SYNC_RST;
      common_r   <= SLC_COMMON_RST;
      bound_r    <= SLC_BOUND_RST;
      psc_r      <= SLC_PSC_OFF;
      load_def_r <= 1'b1;
      rdata_r    <= 16'h0000;
    end else begin
      clk_pwr_r  <= clk_pwr_nxt;
      ext_sync_r <= ext_sync_nxt;
      common_r   <= common_nxt;
      bound_r    <= bound_nxt;
      psc_r      <= psc_nxt;
      load_def_r <= load_def_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Clock request
  // ---------------------------------------------------------------------
  // Request is released only in the cycle after enable and link idle are both seen.
  always_comb begin
    clk_req_nxt = 1'b0;
    if (clk_pwr_r && link_idle) begin
      clk_req_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_req_r <= 1'b0;
    end else begin
      clk_req_r <= clk_req_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  slc_psc_decode u_psc (
    .psc        (psc_r),
    .l0s_permit (l0s_permit),
    .l1_permit  (l1_permit)
  );

  assign cfg_rdata        = rdata_r;
  assign cfg_hit          = sel & (cfg_wr | cfg_rd);
  assign clk_req_n_out    = clk_req_r;
  assign ext_sync         = ext_sync_r;
  assign common_clock     = common_r;
  assign l0s_exit_latency = common_r ? SLC_L0S_LAT_COMMON
                                     : SLC_L0S_LAT_ASYNC;
  // The stored boundary is only a hint from the far end.
  assign own_boundary_128 = 1'b1;

endmodule

// file: slc_link_control_monitor.sv
// Purpose: Port checker for the link control register.
// Assumes: Bound to every slc_link_control instance.
// Notes:   Field state is seen only through permits, common_clock, l0s_exit_latency, clk_req_n_out and read data.
`timescale 1ns/1ps
module slc_link_control_monitor
  import slc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Configuration access
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [1:0]  cfg_be,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic        cfg_hit,
  // Link side
  input wire logic        link_idle,
  input wire logic        clk_req_n_out,
  input wire logic        l0s_permit,
  input wire logic        l1_permit,
  input wire logic [2:0]  l0s_exit_latency,
  input wire logic        common_clock,
  input wire logic        own_boundary_128
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_top_zero: assert property (cfg_rdata[15:12] == 4'h0)
    else $error("top bits set");
  chk_unimpl_zero: assert property (cfg_rdata[11:9] == 3'h0)
    else $error("unimplemented bits set");
  chk_retrain_zero: assert property (cfg_rdata[5:4] == 2'h0)
    else $error("retrain or disable set");
  chk_bit2_zero: assert property (!cfg_rdata[2])
    else $error("bit 2 set");
  chk_latency_sel: assert property (
    l0s_exit_latency == (common_clock ? 3'h3 : 3'h4))
    else $error("exit latency wrong");
  chk_bound_fixed: assert property (own_boundary_128)
    else $error("boundary not 128");
  // A release while the link is busy would stop the clock too early.
  chk_clkreq_idle: assert property (
    clk_req_n_out |-> $past(link_idle))
    else $error("clock request released while busy");
  chk_permit_write: assert property (
    cfg_hit && cfg_wr && cfg_be[0] |=>
    {l1_permit, l0s_permit} == $past(cfg_wdata[1:0]))
    else $error("permits not updated");
  chk_rdata_hold: assert property (
    !(cfg_hit && cfg_rd) |=> $stable(cfg_rdata))
    else $error("read data changed");
  cov_write: cover property (cfg_hit && cfg_wr);
  cov_read: cover property (cfg_hit && cfg_rd);
  cov_release: cover property (clk_req_n_out);
endmodule

bind slc_link_control slc_link_control_monitor u_mon (
  .clk, .rst, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_hit,
  .link_idle, .clk_req_n_out, .l0s_permit, .l1_permit, .l0s_exit_latency,
  .common_clock, .own_boundary_128);

// file: slc_pkg.sv
// Purpose: Constants for the link control register block.
// Assumes: Configuration space access over a 16-bit register window.
// Notes:   Offsets are byte addresses in configuration space.
package slc_pkg;

  // ---------------------------------------------------------------------
  // Offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] SLC_LINK_CONTROL_OFS = 8'h80;
  localparam logic [7:0] SLC_GEN_CONTROL_OFS  = 8'hD4;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int SLC_POS_AUTO_BW_IRQ   = 11;
  localparam int SLC_POS_BW_MGMT_IRQ   = 10;
  localparam int SLC_POS_AUTO_WIDTH    = 9;
  localparam int SLC_POS_CLK_PWR       = 8;
  localparam int SLC_POS_EXT_SYNC      = 7;
  localparam int SLC_POS_COMMON_CLK    = 6;
  localparam int SLC_POS_RETRAIN       = 5;
  localparam int SLC_POS_LINK_DISABLE  = 4;
  localparam int SLC_POS_COMPL_BOUND   = 3;
  localparam int SLC_POS_RSVD2         = 2;
  localparam int SLC_POS_PSC_HI        = 1;
  localparam int SLC_POS_PSC_LO        = 0;
  localparam int SLC_POS_GEN_CLK_PWR   = 23;
  localparam int SLC_POS_GEN_PSC_HI    = 29;
  localparam int SLC_POS_GEN_PSC_LO    = 28;

  // ---------------------------------------------------------------------
  // Masks and reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] SLC_WRITE_MASK   = 16'h01CB;
  localparam logic        SLC_CLK_PWR_RST  = 1'h0;
  localparam logic        SLC_EXT_SYNC_RST = 1'h0;
  localparam logic        SLC_COMMON_RST   = 1'h0;
  localparam logic        SLC_BOUND_RST    = 1'h0;

  // ---------------------------------------------------------------------
  // Exit latency codes and completion boundary
  // ---------------------------------------------------------------------
  localparam logic [2:0] SLC_L0S_LAT_COMMON = 3'h3;
  localparam logic [2:0] SLC_L0S_LAT_ASYNC  = 3'h4;
  localparam int         SLC_OWN_BOUNDARY_BYTES = 128;

  typedef enum logic [1:0] {
    SLC_PSC_OFF  = 2'b00,
    SLC_PSC_L0S  = 2'b01,
    SLC_PSC_L1   = 2'b10,
    SLC_PSC_BOTH = 2'b11
  } slc_psc_t;

endpackage

// file: slc_psc_decode.sv
// Purpose: Decodes the power state control field into entry permits.
// Assumes: Field value comes from the register flip-flops.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module slc_psc_decode
  import slc_pkg::*;
(
  // Field
  input  wire logic [1:0] psc,
  // Permits
  output logic            l0s_permit,
  output logic            l1_permit
);

  always_comb begin
    l0s_permit = 1'b0;
    l1_permit  = 1'b0;
    unique case (slc_psc_t'(psc))
      SLC_PSC_OFF: begin
      end
      SLC_PSC_L0S: begin
        l0s_permit = 1'b1;
      end
      SLC_PSC_L1: begin
        l1_permit = 1'b1;
      end
      SLC_PSC_BOTH: begin
        l0s_permit = 1'b1;
        l1_permit  = 1'b1;
      end
    endcase
  end

endmodule

// file: tb_slc_link_control.sv
// Purpose: Self-checking bench for the link control register.
// Assumes: Strobes are driven as one-cycle pulses.
// Notes:   m holds the expected register image.
`timescale 1ns/1ps
module tb_slc_link_control
  import slc_pkg::*;
;
  logic        clk, rst, cfg_wr, cfg_rd, link_idle, cfg_hit;
  logic        clk_req_n_out, ext_sync, l0s_permit, l1_permit;
  logic        common_clock, own_boundary_128;
  logic [1:0]  cfg_be;
  logic [2:0]  l0s_exit_latency;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, m;
  logic [31:0] gen_control;
  int          num_errors, n_compared, cyc;
  slc_link_control dut (.clk, .rst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_hit, .gen_control, .link_idle,
    .clk_req_n_out, .ext_sync, .l0s_permit, .l1_permit, .l0s_exit_latency,
    .common_clock, .own_boundary_128);
  // -----
  // Tasks
  // -----
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] upd(input logic [15:0] c, d,
                                      input logic [1:0] b);
    logic [15:0] k;
    k = SLC_WRITE_MASK & {{8{b[1]}}, {8{b[0]}}};
    return (c & ~k) | (d & k);
  endfunction
  function automatic logic [15:0] stat(input logic [15:0] r);
    return {8'h00, 1'b1, (r[6] ? 3'h3 : 3'h4), r[6], r[7], r[1:0]};
  endfunction
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [1:0] b, input logic [15:0] d);
    @(posedge clk);
    cfg_wr    <= w;
    cfg_rd    <= !w;
    cfg_addr  <= a;
    cfg_be    <= b;
    cfg_wdata <= d;
    #1;
    chk({15'h0000, cfg_hit}, {15'h0000, a == SLC_LINK_CONTROL_OFS});
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    if (w && a == SLC_LINK_CONTROL_OFS) m = upd(m, d, b);
    #1;
  endtask
  task automatic rdchk();
    acc(1'b0, SLC_LINK_CONTROL_OFS, 2'h3, 16'h0000);
    chk(cfg_rdata, m);
    chk({8'h00, own_boundary_128, l0s_exit_latency, common_clock,
         ext_sync, l1_permit, l0s_permit}, stat(m));
    chk({15'h0000, clk_req_n_out}, {15'h0000, m[8] & link_idle});
  endtask
  task automatic do_reset(input logic [31:0] g);
    @(posedge clk);
    rst         <= 1'b1;
    gen_control <= g;
    m = {7'h00, g[23], 6'h00, g[29:28]};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang ends the run here rather than stalling it.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    // Reset stands from time zero so no check sees unset flip-flops.
    rst = 1'b1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    gen_control = 32'h0000_0000;
    link_idle = 1'b1;
    {num_errors, n_compared, cyc} = '0;
    m = 16'h0000;
    void'($urandom(32'h4332));
    do_reset(32'h3080_0000);
    rdchk();
    acc(1'b1, SLC_LINK_CONTROL_OFS, 2'h3, 16'hFFFF);
    rdchk();
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, SLC_LINK_CONTROL_OFS, 2'h1, 16'(i));
      rdchk();
    end
    acc(1'b1, SLC_LINK_CONTROL_OFS, 2'h2, 16'h0000);
    rdchk();
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      link_idle   <= 1'($urandom);
      gen_control <= $urandom;
      acc(1'b1, ($urandom % 4 == 0) ? 8'h84 : SLC_LINK_CONTROL_OFS,
          2'($urandom), 16'($urandom));
      rdchk();
      acc(1'b0, 8'h84, 2'h3, 16'h0000);
      chk(cfg_rdata, m);
    end
    do_reset(32'h1000_0000);
    rdchk();
    summarize();
  end
endmodule
